// File: rlc_divider.sv
// Binary weighted divider after the ring.
// Assumes ring_tick is a one-cycle pulse per ring period.
`timescale 1ns/1ps
`default_nettype none
module rlc_divider
   import rlc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   rlc_osc_if.div osc
);
   logic [8:0] cnt;
   logic [8:0] top;
   logic [8:0] half;

   // [RULE2] [RULE3] [RULE4] [RULE5] Ratio is two to the code
   assign top = 9'((10'h001 << rlc_eff_div(osc.power_divider_code)) - 10'h1);
   assign half = 9'(10'((10'h001 << rlc_eff_div(osc.power_divider_code))) >> 1);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 9'h000;
         osc.internal_clock_tick <= 1'b0;
         osc.internal_clock <= 1'b0;
      end
      else if (!osc.run)
      begin
         cnt <= 9'h000;
         osc.internal_clock_tick <= 1'b0;
         osc.internal_clock <= 1'b0;
      end
      else if (osc.ring_tick)
      begin
         cnt <= (cnt >= top) ? 9'h000 : cnt + 9'h001;
         osc.internal_clock_tick <= (cnt >= top);
         // Undivided case toggles once per ring period
         if (top == 9'h000)
            osc.internal_clock <= ~osc.internal_clock;
         else
            osc.internal_clock <= (cnt >= top) || (cnt + 9'h001 < half);
      end
      else
         osc.internal_clock_tick <= 1'b0;
   end
endmodule
`default_nettype wire

// File: rlc_loop_control.sv
// Loop filter of the internal clock generator ring oscillator.
// Assumes base_tick pulses once per low-frequency base clock period.
//
// Function
// [RULE1] Drive eight stage and four divider bits
// [RULE2] Divider ratio is two to code
// [RULE3] Codes ten to fifteen act as nine
// [RULE4] Code zero passes ring undivided
// [RULE5] Code step doubles or halves period
// [RULE6] Divider moves only by stage carry/borrow
// [RULE7] Ring length is seventeen plus twice top
// [RULE8] Fine code k: k long cycles per 32
// [RULE9] Fine zero keeps nominal length always
// [RULE10] Top all ones: long is 17 halved
// [RULE11] Large error uses bit five steps
// [RULE12] Small error uses bit zero steps
// [RULE13] Regulate to factor times base clock
// [RULE14] Software disables monitor before factor write
// [RULE15] Monitor re-enable waits for stable
// [RULE16] Software follows documented change sequence
// [RULE17] Re-settle after reset, writes, restart
// [RULE18] Correction spans four base periods
// [RULE19] Eight coarse steps double the period
// [RULE20] Combined code saturates, never wraps
`timescale 1ns/1ps
`default_nettype none
module rlc_loop_control
   import rlc_pkg::*;
#(
   parameter int FACTOR_BITS = FACTOR_W
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic base_tick,
   input wire logic [FACTOR_BITS-1:0] multiply_factor,
   input wire logic factor_write,
   input wire logic trim_write,
   input wire logic generator_on,
   input wire logic stop_mode,
   input wire logic external_stable,
   input wire logic monitor_request,
   input wire logic monitor_flag,
   output logic [STG_W-1:0] ring_stage_code,
   output logic [DIV_W-1:0] power_divider_code,
   output logic internal_clock,
   output logic internal_clock_tick,
   output logic internal_clock_stable,
   output logic monitor_enable,
   output logic coarse_mode
);
   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_q1;
   logic rst_n;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // ------------------------------------------------------------
   // Oscillator models
   // ------------------------------------------------------------
   rlc_osc_if osc ();

   rlc_ring u_ring (
      .clk(clk),
      .rst_n(rst_n),
      .osc(osc)
   );

   rlc_divider u_div (
      .clk(clk),
      .rst_n(rst_n),
      .osc(osc)
   );

   // ------------------------------------------------------------
   // Run and re-settle detection
   // ------------------------------------------------------------
   logic run;
   logic run_prev;
   logic resettle;

   assign run = generator_on && !stop_mode;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         run_prev <= 1'b0;
      else if (!rst_n)
         run_prev <= 1'b0;
      else
         run_prev <= run;
   end

   // [RULE17] Restart, factor or trim write re-settles
   assign resettle = (run && !run_prev) || factor_write || trim_write;

   // ------------------------------------------------------------
   // Measurement window
   // ------------------------------------------------------------
   rlc_state_type state;
   rlc_state_type next_state;
   logic [2:0] base_cnt;
   logic [CNT_W-1:0] tick_cnt;
   logic [CNT_W-1:0] target;
   logic [CNT_W-1:0] err_mag;
   logic too_fast;
   logic large_err;
   logic synced;

   // [RULE13] [RULE18] Expect four times factor ticks
   assign target = CNT_W'({multiply_factor, 2'b00});
   assign too_fast = tick_cnt > target;
   assign err_mag = too_fast ? tick_cnt - target : target - tick_cnt;
   // Error above fifteen percent, scaled to avoid division
   // Wide enough for a saturated count times one hundred
   assign large_err = (18'(err_mag) * 18'd100)
      > (18'(target) * 18'(COARSE_PCT));

   always_comb
   begin
      next_state = state;
      case (state)
         RLC_IDLE:
            if (run)
               next_state = RLC_MEASURE;
         RLC_MEASURE:
            if (!run)
               next_state = RLC_IDLE;
            // [RULE18] Window closes on fourth base period
            else if (base_tick && base_cnt == CORR_PERIODS - 3'h1)
               next_state = RLC_CORRECT;
         RLC_CORRECT:
            next_state = run ? RLC_MEASURE : RLC_IDLE;
         default:
            next_state = RLC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state <= RLC_IDLE;
      else if (!rst_n)
         state <= RLC_IDLE;
      else if (resettle && run)
         state <= RLC_MEASURE;
      else
         state <= next_state;
   end

   // [RULE18] First window waits for a base tick
   // A window opened mid-period would be short and misjudge
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         synced <= 1'b0;
      else if (!rst_n || !run || resettle)
         synced <= 1'b0;
      else if (base_tick && state == RLC_MEASURE)
         synced <= 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         base_cnt <= 3'h0;
         tick_cnt <= 10'h000;
      end
      else if (!rst_n || state != RLC_MEASURE || resettle || !synced)
      begin
         base_cnt <= 3'h0;
         tick_cnt <= 10'h000;
      end
      else
      begin
         if (base_tick)
            base_cnt <= base_cnt + 3'h1;
         // Saturate so a runaway clock still reads as too fast
         if (osc.internal_clock_tick && tick_cnt != CNT_MAX)
            tick_cnt <= tick_cnt + 10'h001;
      end
   end

   // ------------------------------------------------------------
   // Combined divider and stage code
   // ------------------------------------------------------------
   logic [CODE_W-1:0] code;
   logic [CODE_W-1:0] step;
   logic [CODE_W:0] code_up;
   logic [CODE_W-1:0] next_code;

   always_comb
   begin
      // [RULE11] [RULE19] Coarse bit five, eight per octave
      // [RULE12] Least stage bit once error is small
      step = large_err ? COARSE_STEP : FINE_STEP;
      code_up = {1'b0, code} + {1'b0, step};
      next_code = code;
      if (tick_cnt != target)
      begin
         if (too_fast)
         begin
            // [RULE20] Ceiling at top divider with full stages
            if (code_up > {1'b0, CODE_MAX})
               next_code = CODE_MAX;
            else
               next_code = code_up[CODE_W-1:0];
         end
         else
         begin
            // [RULE20] Floor at all zeros
            if (code < step)
               next_code = CODE_MIN;
            else
               next_code = code - step;
         end
      end
   end

   // [RULE6] Divider moves only through stage carry or borrow
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         code <= CODE_RESET;
      else if (!rst_n)
         code <= CODE_RESET;
      else if (state == RLC_CORRECT)
         code <= next_code;
   end

   // ------------------------------------------------------------
   // Stable indication
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         internal_clock_stable <= 1'b0;
         coarse_mode <= 1'b1;
      end
      else if (!rst_n || !run || resettle)
      begin
         internal_clock_stable <= 1'b0;
         coarse_mode <= 1'b1;
      end
      else if (state == RLC_CORRECT)
      begin
         internal_clock_stable <= !large_err;
         coarse_mode <= large_err;
      end
   end

   // ------------------------------------------------------------
   // Clock monitor enable
   // ------------------------------------------------------------
   // Held while requested and running; a fresh enable needs both clocks stable
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         monitor_enable <= 1'b0;
      else if (!rst_n || !monitor_request || !run)
         monitor_enable <= 1'b0;
      // [RULE15] Refuse enable until stable again
      else if (!monitor_enable && !monitor_flag)
         monitor_enable <= internal_clock_stable && external_stable;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // [RULE1] Stage and divider fields to the oscillator
   assign osc.run = run && rst_n;
   assign osc.ring_stage_code = code[STG_W-1:0];
   assign osc.power_divider_code = code[CODE_W-1:STG_W];

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ring_stage_code <= CODE_RESET[STG_W-1:0];
         power_divider_code <= CODE_RESET[CODE_W-1:STG_W];
         internal_clock <= 1'b0;
         internal_clock_tick <= 1'b0;
      end
      else
      begin
         ring_stage_code <= code[STG_W-1:0];
         power_divider_code <= rlc_eff_div(code[CODE_W-1:STG_W]);
         internal_clock <= osc.internal_clock;
         internal_clock_tick <= osc.internal_clock_tick;
      end
   end
endmodule
`default_nettype wire

// File: rlc_loop_control_sva.sv
// Checker for the ring oscillator loop control top ports.
// Assumes it is bound to rlc_loop_control.
`timescale 1ns/1ps
`default_nettype none
module rlc_loop_control_sva
   import rlc_pkg::*;
#(
   parameter int FACTOR_BITS = FACTOR_W
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic base_tick,
   input wire logic [FACTOR_BITS-1:0] multiply_factor,
   input wire logic factor_write,
   input wire logic trim_write,
   input wire logic generator_on,
   input wire logic stop_mode,
   input wire logic external_stable,
   input wire logic monitor_request,
   input wire logic monitor_flag,
   input wire logic [STG_W-1:0] ring_stage_code,
   input wire logic [DIV_W-1:0] power_divider_code,
   input wire logic internal_clock,
   input wire logic internal_clock_tick,
   input wire logic internal_clock_stable,
   input wire logic monitor_enable,
   input wire logic coarse_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [CODE_W-1:0] code;
   logic [CODE_W-1:0] code_q;
   logic [2:0] nb;
   assign code = {power_divider_code, ring_stage_code};
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         code_q <= CODE_RESET;
      else
         code_q <= code;
   end
   // Base ticks seen since the last code change, stops at four
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         nb <= 3'h0;
      else if (code != code_q)
         nb <= {2'b00, base_tick};
      else if (base_tick && nb < 3'h4)
         nb <= nb + 3'h1;
   end
   a_div_range: assert property (power_divider_code <= DIV_MAX)
      else $error("divider code above nine");
   a_step_size: assert property (code != code_q |->
      (code - code_q) <= COARSE_STEP || (code_q - code) <= COARSE_STEP)
      else $error("code moved by more than one coarse step");
   a_corr_spacing: assert property (code != code_q |-> nb >= 3'h4)
      else $error("correction before four base periods");
   a_tick_gap: assert property (internal_clock_tick |=>
      !internal_clock_tick [*8])
      else $error("internal clock ticks too close");
   a_mon_cause: assert property ($rose(monitor_enable) |->
      $past(monitor_request & internal_clock_stable & external_stable
      & !monitor_flag))
      else $error("monitor enabled without its conditions");
   a_mon_drop: assert property ((!monitor_request || !generator_on ||
      stop_mode) |=> !monitor_enable)
      else $error("monitor stayed enabled");
   a_resettle_clear: assert property ((factor_write || trim_write) |->
      ##[1:3] !internal_clock_stable)
      else $error("stable kept after a factor write");
   a_stop_clear: assert property (stop_mode |->
      ##[1:3] !internal_clock_stable)
      else $error("stable kept while stopped");
   a_hold_off: assert property ((!generator_on) [*4] |=>
      $stable(code))
      else $error("code moved while generator off");
endmodule
bind rlc_loop_control rlc_loop_control_sva #(.FACTOR_BITS(FACTOR_BITS))
   i_sva (.clk(clk), .arst_n(arst_n), .base_tick(base_tick),
   .multiply_factor(multiply_factor), .factor_write(factor_write),
   .trim_write(trim_write), .generator_on(generator_on),
   .stop_mode(stop_mode), .external_stable(external_stable),
   .monitor_request(monitor_request), .monitor_flag(monitor_flag),
   .ring_stage_code(ring_stage_code),
   .power_divider_code(power_divider_code),
   .internal_clock(internal_clock),
   .internal_clock_tick(internal_clock_tick),
   .internal_clock_stable(internal_clock_stable),
   .monitor_enable(monitor_enable), .coarse_mode(coarse_mode));
`default_nettype wire

// File: rlc_loop_control_tb.sv
// Self-checking bench for the ring oscillator loop control.
// Assumes the bound checker; base clock is a bench pulse train.
`timescale 1ns/1ps
`default_nettype none
module rlc_loop_control_tb;
   import rlc_pkg::*;
   logic clk = 0, arst_n = 0, base_tick = 0, factor_write = 0;
   logic trim_write = 0, generator_on = 0, stop_mode = 0;
   logic external_stable = 0, monitor_request = 0, monitor_flag = 0;
   logic [FACTOR_W-1:0] multiply_factor = 7'h04;
   logic [STG_W-1:0] ring_stage_code;
   logic [DIV_W-1:0] power_divider_code;
   logic internal_clock, internal_clock_tick, internal_clock_stable;
   logic monitor_enable, coarse_mode;
   logic [CODE_W-1:0] code, held;
   int err_count = 0, checks = 0, base_per = 0, bcnt = 0, chg, i;
   int seed = 32'h0ec134a3;
   assign code = {power_divider_code, ring_stage_code};
   rlc_loop_control i_dut (.clk(clk), .arst_n(arst_n),
      .base_tick(base_tick), .multiply_factor(multiply_factor),
      .factor_write(factor_write), .trim_write(trim_write),
      .generator_on(generator_on), .stop_mode(stop_mode),
      .external_stable(external_stable),
      .monitor_request(monitor_request), .monitor_flag(monitor_flag),
      .ring_stage_code(ring_stage_code),
      .power_divider_code(power_divider_code),
      .internal_clock(internal_clock),
      .internal_clock_tick(internal_clock_tick),
      .internal_clock_stable(internal_clock_stable),
      .monitor_enable(monitor_enable), .coarse_mode(coarse_mode));
   initial
   begin
      forever #25 clk = ~clk;
   end
   // Base clock stand-in; period zero freezes the loop
   always @(posedge clk)
   begin
      #2;
      base_tick = (base_per != 0 && bcnt >= base_per - 1);
      bcnt = base_tick ? 0 : bcnt + 1;
   end
   task automatic wrap_up();
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // Clocks over 32 internal clock periods; per 32 ring periods dither carries sum to the fine code
   function automatic int exp_per(input logic [11:0] c);
      int d;
      d = (c[11:8] > 4'h9) ? 9 : c[11:8];
      return (32 * (17 + 2 * c[7:5]) + c[4:0] * ((c[7:5] == 7) ? 3 : 2))
         << d;
   endfunction
   task automatic measure(input logic [11:0] cw);
      int c, k, r;
      logic lv;
      c = 0;
      k = 0;
      r = 0;
      while (internal_clock_tick !== 1'b1 && c < 4000)
      begin
         tk(1);
         c++;
      end
      c = 0;
      lv = internal_clock;
      while (k < 32 && c < 4000)
      begin
         tk(1);
         c++;
         k += (internal_clock_tick === 1'b1);
         r += (internal_clock === 1'b1 && lv === 1'b0);
         lv = internal_clock;
      end
      chk(c, exp_per(cw));
      // Undivided clock toggles per period, so half the rises
      chk(r, (cw[11:8] == 4'h0) ? 16 : 32);
      if (k < 32)
         wrap_up();
   endtask
   task automatic settle(input logic [11:0] tgt, input int bound,
      output int n);
      int t;
      logic [11:0] prev;
      t = 0;
      n = 0;
      prev = code;
      while (code !== tgt && t < bound)
      begin
         tk(1);
         n += (code !== prev);
         prev = code;
         t++;
      end
      if (t >= bound)
      begin
         chk(code, tgt);
         wrap_up();
      end
   endtask
   task automatic set_n(input logic [6:0] n, input int per);
      multiply_factor = n;
      factor_write = 1;
      tk(1);
      factor_write = 0;
      base_per = per;
   endtask
   initial
   begin
      tk(8);
      arst_n = 1;
      chk({code, internal_clock_stable, monitor_enable, coarse_mode},
         {CODE_RESET, 3'b001});
      tk(4);
      generator_on = 1;
      measure(12'h080);
      // Too slow: coarse steps down, then held at zero
      set_n(7'h7f, 20);
      settle(12'h000, 4000, chg);
      chk(chg, 4);
      tk(900);
      chk(code, 12'h000);
      base_per = 0;
      measure(12'h000);
      // Too fast: eight coarse steps carry into the divider
      trim_write = 1;
      tk(1);
      trim_write = 0;
      set_n(7'h01, 600);
      settle(12'h100, 30000, chg);
      base_per = 0;
      chk(chg, 8);
      measure(12'h100);
      // Near target: single-bit steps, stable set
      set_n(7'h04, 145);
      tk(7000);
      chk({coarse_mode, internal_clock_stable}, 2'b01);
      chk(code > 12'h100 && code < 12'h120, 1);
      external_stable = 1;
      monitor_flag = 1;
      monitor_request = 1;
      tk(4);
      chk(monitor_enable, 0);
      monitor_flag = 0;
      tk(3);
      chk(monitor_enable, 1);
      for (i = 0; i < 100; i++)
      begin
         {monitor_request, monitor_flag, external_stable} = 3'($random(seed));
         tk(1);
      end
      // Flag clear, monitor off, then write
      {monitor_request, monitor_flag, external_stable} = 3'b001;
      tk(2);
      chk(monitor_enable, 0);
      set_n(7'h04, 145);
      tk(3);
      chk(internal_clock_stable, 0);
      monitor_request = 1;
      tk(3);
      chk(monitor_enable, 0);
      // One window after sync: stable again, monitor follows
      tk(800);
      chk({internal_clock_stable, monitor_enable}, 2'b11);
      held = code;
      stop_mode = 1;
      tk(6);
      chk({code, internal_clock_stable, monitor_enable},
         {held, 2'b00});
      wrap_up();
   end
endmodule
`default_nettype wire

// File: rlc_osc_if.sv
// Carrier between loop control and the oscillator models.
// Assumes all members are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
interface rlc_osc_if;
   import rlc_pkg::*;
   logic run;
   logic [STG_W-1:0] ring_stage_code;
   logic [DIV_W-1:0] power_divider_code;
   logic ring_tick;
   logic internal_clock_tick;
   logic internal_clock;
   modport ctrl (output run, output ring_stage_code,
      output power_divider_code, input internal_clock_tick,
      input internal_clock);
   modport ring (input run, input ring_stage_code, output ring_tick);
   modport div (input run, input power_divider_code, input ring_tick,
      output internal_clock_tick, output internal_clock);
endinterface
`default_nettype wire

// File: rlc_pkg.sv
// Constants and types shared by the ring oscillator loop control block.
// Assumes one 20 MHz clock domain and a synchronous reset copy.
package rlc_pkg;

   // ------------------------------------------------------------
   // Widths and code limits
   // ------------------------------------------------------------
   localparam int STG_W = 8;
   localparam int DIV_W = 4;
   localparam int FINE_W = 5;
   localparam int CODE_W = 12;
   localparam int FACTOR_W = 7;
   localparam int CNT_W = 10;
   localparam logic [DIV_W-1:0] DIV_MAX = 4'h9;
   localparam logic [CODE_W-1:0] CODE_MAX = 12'h9ff;
   localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
   localparam logic [CODE_W-1:0] CODE_RESET = 12'h080;
   localparam logic [CODE_W-1:0] COARSE_STEP = 12'h020;
   localparam logic [CODE_W-1:0] FINE_STEP = 12'h001;
   localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;

   // ------------------------------------------------------------
   // Ring geometry
   // ------------------------------------------------------------
   localparam logic [5:0] RING_BASE = 6'h11;
   localparam logic [5:0] RING_EXTRA = 6'h02;
   localparam logic [2:0] RING_TOP = 3'h7;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int BASE_HZ = 307200;
   localparam logic [2:0] CORR_PERIODS = 3'h4;
   localparam int COARSE_PCT = 15;

   typedef enum logic [1:0]
   {
      RLC_IDLE = 2'b00,
      RLC_MEASURE = 2'b01,
      RLC_CORRECT = 2'b10
   } rlc_state_type;

   // Codes above nine behave as nine
   function automatic logic [DIV_W-1:0] rlc_eff_div(
      input logic [DIV_W-1:0] code);
      rlc_eff_div = (code > DIV_MAX) ? DIV_MAX : code;
   endfunction

endpackage

// File: rlc_ring.sv
// Digital model of the variable-delay ring with fine-adjust dither.
// Assumes one stage delay equals one clk cycle.
`timescale 1ns/1ps
`default_nettype none
module rlc_ring
   import rlc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   rlc_osc_if.ring osc
);
   logic [5:0] cnt;
   logic [5:0] len;
   logic [FINE_W-1:0] acc;
   logic [FINE_W:0] acc_sum;
   logic long_now;
   logic half;
   logic [2:0] top;

   assign top = osc.ring_stage_code[7:5];
   assign acc_sum = {1'b0, acc} + {1'b0, osc.ring_stage_code[4:0]};

   // ------------------------------------------------------------
   // Period length
   // ------------------------------------------------------------
   always_comb
   begin
      // [RULE7] Nominal ring length
      len = RING_BASE + {2'b00, top, 1'b0};
      // [RULE10] Top code stretches via half-rate
      if (long_now && top == RING_TOP)
         len = RING_BASE;
      else if (long_now)
         len = len + RING_EXTRA;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 6'h00;
         acc <= 5'h00;
         long_now <= 1'b0;
         half <= 1'b0;
         osc.ring_tick <= 1'b0;
      end
      else if (!osc.run)
      begin
         cnt <= 6'h00;
         half <= 1'b0;
         osc.ring_tick <= 1'b0;
      end
      else if (cnt == len - 6'h01)
      begin
         cnt <= 6'h00;
         // [RULE10] Divide by two on the long 17-stage state
         if (long_now && top == RING_TOP && !half)
         begin
            half <= 1'b1;
            osc.ring_tick <= 1'b0;
         end
         else
         begin
            half <= 1'b0;
            osc.ring_tick <= 1'b1;
            // [RULE8] [RULE9] Carry marks k of 32 long cycles
            acc <= acc_sum[FINE_W-1:0];
            long_now <= acc_sum[FINE_W];
         end
      end
      else
      begin
         cnt <= cnt + 6'h01;
         osc.ring_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire
